// file: design/vectored_irq_unit.v
// vectored interrupt controller: classes, slot priority, vector address
// assumes peripheral request lines are levels in the clk_i domain,
// external request pins are asynchronous, registers reached over wishbone
//
// Operation
// - sort each request into fast, vectored, non-vectored
// - class and slots changeable at run time
// - fast class wins; fast requests merged into one
// - status word shows requesting fast sources
// - sixteen vectored slots take any channel
// - slot 0 highest, slot 15 lowest priority
// - non-vectored lowest; normal output merges both
// - vector read gives winner or default address
// - register shows active normal-class request lines
// - one request line per peripheral, two for debug; spi1 and sync port share one
// - channel 0 watchdog, 1 software, 2/3 debug
// - channels 4-5 timers, 6-7 serial, 8 pwm
// - channels 9-12 two-wire, spi, spi/sync, synth
// - channel 13 clock, channel 18 converter
// - external requests on channels 14 to 17
//
// Design decisions made here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`include "vectored_irq_unit_defines.vh"

module vectored_irq_unit (
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [11:0] adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // peripheral request lines
    input  wire        watchdog_request_i,
    input  wire        debug_comm_receive_i,
    input  wire        debug_comm_transmit_i,
    input  wire        timer0_match_i,
    input  wire        timer1_match_i,
    input  wire        serial0_request_i,
    input  wire        serial1_request_i,
    input  wire        pwm_match_i,
    input  wire        two_wire_state_i,
    input  wire        spi0_request_i,
    input  wire        spi1_request_i,
    input  wire        sync_port_request_i,
    input  wire        synth_lock_flag_i,
    input  wire        clock_increment_flag_i,
    input  wire        clock_alarm_flag_i,
    input  wire        ext_request_zero_i,
    input  wire        ext_request_one_i,
    input  wire        ext_request_two_i,
    input  wire        ext_request_three_i,
    input  wire        adc_done_i,
    // to the processor
    output reg         fast_request_o,
    output reg         normal_request_o,
    output reg         irq_o
);

    // ----------------------------------------------------------------
    // request assembly
    // ----------------------------------------------------------------
    reg  [3:0]  ext_meta_q;
    reg  [3:0]  ext_sync_q;
    reg         soft_q;
    wire [31:0] raw_w;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ext_meta_q <= 4'h0;
            ext_sync_q <= 4'h0;
        end
        else
        begin
            ext_meta_q <= {ext_request_three_i, ext_request_two_i,
                           ext_request_one_i, ext_request_zero_i};
            ext_sync_q <= ext_meta_q;
        end
    end

    assign raw_w[`VIU_CH_WATCHDOG]  = watchdog_request_i;
    assign raw_w[`VIU_CH_SOFT]      = soft_q;
    assign raw_w[`VIU_CH_DBG_RX]    = debug_comm_receive_i;
    assign raw_w[`VIU_CH_DBG_TX]    = debug_comm_transmit_i;
    assign raw_w[`VIU_CH_TIMER0]    = timer0_match_i;
    assign raw_w[`VIU_CH_TIMER1]    = timer1_match_i;
    assign raw_w[`VIU_CH_SERIAL0]   = serial0_request_i;
    assign raw_w[`VIU_CH_SERIAL1]   = serial1_request_i;
    assign raw_w[`VIU_CH_PWM]       = pwm_match_i;
    assign raw_w[`VIU_CH_TWO_WIRE]  = two_wire_state_i;
    assign raw_w[`VIU_CH_SPI0]      = spi0_request_i;
    // shared line: either source raises it
    assign raw_w[`VIU_CH_SPI1_SYNC] = spi1_request_i
                                    | sync_port_request_i;
    assign raw_w[`VIU_CH_SYNTH]     = synth_lock_flag_i;
    assign raw_w[`VIU_CH_CLOCK]     = clock_increment_flag_i
                                    | clock_alarm_flag_i;
    assign raw_w[`VIU_CH_EXT0+3:`VIU_CH_EXT0] = ext_sync_q;
    assign raw_w[`VIU_CH_ADC]       = adc_done_i;
    assign raw_w[31:`VIU_NUSED]     = 13'h0000;

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    reg  [31:0] class_q;      // 1 = fast class
    reg  [31:0] enable_q;
    reg  [31:0] def_addr_q;
    reg  [31:0] slot_addr_q [0:`VIU_NSLOT-1];
    reg  [5:0]  slot_ctrl_q [0:`VIU_NSLOT-1];
    reg  [2:0]  evt_stat_q;
    reg  [2:0]  evt_mask_q;

    wire [31:0] en_w    = raw_w & enable_q;
    wire [31:0] fast_w  = en_w & class_q;
    wire [31:0] norm_w  = en_w & ~class_q;

    // ----------------------------------------------------------------
    // slot priority
    // ----------------------------------------------------------------
    wire [`VIU_NSLOT-1:0] slot_hit_w;
    genvar g;
    generate
        for (g = 0; g < `VIU_NSLOT; g = g + 1)
        begin : g_slot
            assign slot_hit_w[g] = slot_ctrl_q[g][`VIU_SLOT_EN_BIT]
                & norm_w[slot_ctrl_q[g][`VIU_CHAN_W-1:0]];
        end
    endgenerate

    // mask of channels bound to an enabled slot
    reg  [31:0] vect_chan_w;
    integer     k;
    always @*
    begin
        vect_chan_w = 32'h0000_0000;
        for (k = 0; k < `VIU_NSLOT; k = k + 1)
            if (slot_ctrl_q[k][`VIU_SLOT_EN_BIT])
                vect_chan_w[slot_ctrl_q[k][`VIU_CHAN_W-1:0]] = 1'b1;
    end

    // lowest index wins
    reg  [31:0] vect_addr_w;
    integer     j;
    always @*
    begin
        vect_addr_w = def_addr_q;
        for (j = `VIU_NSLOT - 1; j >= 0; j = j - 1)
            if (slot_hit_w[j])
                vect_addr_w = slot_addr_q[j];
    end

    wire fast_any_w  = |fast_w;
    wire norm_any_w  = |norm_w;
    wire vect_any_w  = |slot_hit_w;
    wire nvect_any_w = |(norm_w & ~vect_chan_w);

    // ----------------------------------------------------------------
    // wishbone slave
    // ----------------------------------------------------------------
    wire req_w = cyc_i & stb_i & ~ack_o;
    wire wr_w  = req_w & we_i;

    function [31:0] merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  sel_v;
        integer b;
        begin
            merge = old_v;
            for (b = 0; b < 4; b = b + 1)
                if (sel_v[b])
                    merge[b*8 +: 8] = new_v[b*8 +: 8];
        end
    endfunction

    wire [31:0] wmask_w = {{8{sel_i[3]}}, {8{sel_i[2]}},
                           {8{sel_i[1]}}, {8{sel_i[0]}}};
    wire [31:0] wset_w  = dat_i & wmask_w;

    wire in_slot_addr_w = (adr_i[11:6] == `VIU_SLOT_ADDR >> 6);
    wire in_slot_ctrl_w = (adr_i[11:6] == `VIU_SLOT_CTRL >> 6);
    wire [3:0] slot_idx_w = adr_i[5:2];

    reg [31:0] rd_w;
    always @*
    begin
        if (adr_i == `VIU_IRQ_STATUS)
            rd_w = norm_w;
        else if (adr_i == `VIU_FAST_STATUS)
            rd_w = fast_w;
        else if (adr_i == `VIU_RAW_STATUS)
            rd_w = raw_w;
        else if (adr_i == `VIU_CLASS_SEL)
            rd_w = class_q;
        else if (adr_i == `VIU_ENABLE)
            rd_w = enable_q;
        else if (adr_i == `VIU_SOFT_SET)
            rd_w = {31'h0000_0000, soft_q};
        else if (adr_i == `VIU_VECT_ADDR)
            rd_w = vect_addr_w;
        else if (adr_i == `VIU_DEF_ADDR)
            rd_w = def_addr_q;
        else if (adr_i == `VIU_EVT_STATUS)
            rd_w = {29'h0000_0000, evt_stat_q};
        else if (adr_i == `VIU_EVT_MASK)
            rd_w = {29'h0000_0000, evt_mask_q};
        else if (in_slot_addr_w)
            rd_w = slot_addr_q[slot_idx_w];
        else if (in_slot_ctrl_w)
            rd_w = {26'h000_0000, slot_ctrl_q[slot_idx_w]};
        else
            rd_w = `VIU_RESET_WORD;
    end

    // events: rising edges of the class summaries
    reg  [2:0] evt_lvl_q;
    wire [2:0] evt_lvl_w = {nvect_any_w, vect_any_w, fast_any_w};
    wire [2:0] evt_rise_w = evt_lvl_w & ~evt_lvl_q;

    integer s;
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o      <= 1'b0;
            dat_o      <= `VIU_RESET_WORD;
            class_q    <= `VIU_RESET_WORD;
            enable_q   <= `VIU_RESET_WORD;
            def_addr_q <= `VIU_RESET_WORD;
            soft_q     <= 1'b0;
            evt_stat_q <= 3'h0;
            evt_mask_q <= 3'h0;
            evt_lvl_q  <= 3'h0;
            for (s = 0; s < `VIU_NSLOT; s = s + 1)
            begin
                slot_addr_q[s] <= `VIU_RESET_WORD;
                slot_ctrl_q[s] <= 6'h00;
            end
        end
        else
        begin
            ack_o     <= req_w;
            dat_o     <= req_w ? rd_w : `VIU_RESET_WORD;
            evt_lvl_q <= evt_lvl_w;
            // set beats a same-cycle write-one clear
            if (wr_w && adr_i == `VIU_EVT_STATUS)
                evt_stat_q <= (evt_stat_q & ~wset_w[2:0]) | evt_rise_w;
            else
                evt_stat_q <= evt_stat_q | evt_rise_w;
            if (wr_w)
            begin
                // all of these may change while running, no reset
                if (adr_i == `VIU_CLASS_SEL)
                    class_q <= merge(class_q, dat_i, sel_i);
                else if (adr_i == `VIU_ENABLE)
                    enable_q <= enable_q | wset_w;
                else if (adr_i == `VIU_ENABLE_CLR)
                    enable_q <= enable_q & ~wset_w;
                else if (adr_i == `VIU_SOFT_SET && wset_w[0])
                    soft_q <= 1'b1;
                else if (adr_i == `VIU_SOFT_CLR && wset_w[0])
                    soft_q <= 1'b0;
                else if (adr_i == `VIU_DEF_ADDR)
                    def_addr_q <= merge(def_addr_q, dat_i, sel_i);
                else if (adr_i == `VIU_EVT_MASK && sel_i[0])
                    evt_mask_q <= dat_i[2:0];
                else if (in_slot_addr_w)
                    slot_addr_q[slot_idx_w] <=
                        merge(slot_addr_q[slot_idx_w], dat_i, sel_i);
                else if (in_slot_ctrl_w && sel_i[0])
                    slot_ctrl_q[slot_idx_w] <= dat_i[5:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs: registered; fast and normal one cycle behind the request level, irq two via evt_stat_q
    // ----------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fast_request_o   <= 1'b0;
            normal_request_o <= 1'b0;
            irq_o            <= 1'b0;
        end
        else
        begin
            fast_request_o   <= fast_any_w;
            normal_request_o <= norm_any_w;
            irq_o            <= |(evt_stat_q & evt_mask_q);
        end
    end

endmodule // vectored_irq_unit

// file: design/vectored_irq_unit_defines.vh
// register offsets, field layouts and reset values of the vectored irq unit
// assumes a 32-bit classic wishbone slave with word-aligned registers
`ifndef VECTORED_IRQ_UNIT_DEFINES_VH
`define VECTORED_IRQ_UNIT_DEFINES_VH

`define VIU_NCHAN        32
`define VIU_NSLOT        16
`define VIU_CHAN_W       5
`define VIU_ADR_W        12

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define VIU_IRQ_STATUS   12'h000
`define VIU_FAST_STATUS  12'h004
`define VIU_RAW_STATUS   12'h008
`define VIU_CLASS_SEL    12'h00C
`define VIU_ENABLE       12'h010
`define VIU_ENABLE_CLR   12'h014
`define VIU_SOFT_SET     12'h018
`define VIU_SOFT_CLR     12'h01C
`define VIU_VECT_ADDR    12'h030
`define VIU_DEF_ADDR     12'h034
`define VIU_EVT_STATUS   12'h040
`define VIU_EVT_MASK     12'h044
`define VIU_SLOT_ADDR    12'h100
`define VIU_SLOT_CTRL    12'h200

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define VIU_SLOT_EN_BIT  5
`define VIU_EVT_FAST     0
`define VIU_EVT_VECT     1
`define VIU_EVT_NONVECT  2
`define VIU_EVT_W        3

// ----------------------------------------------------------------
// channel map
// ----------------------------------------------------------------
`define VIU_CH_WATCHDOG  0
`define VIU_CH_SOFT      1
`define VIU_CH_DBG_RX    2
`define VIU_CH_DBG_TX    3
`define VIU_CH_TIMER0    4
`define VIU_CH_TIMER1    5
`define VIU_CH_SERIAL0   6
`define VIU_CH_SERIAL1   7
`define VIU_CH_PWM       8
`define VIU_CH_TWO_WIRE  9
`define VIU_CH_SPI0      10
`define VIU_CH_SPI1_SYNC 11
`define VIU_CH_SYNTH     12
`define VIU_CH_CLOCK     13
`define VIU_CH_EXT0      14
`define VIU_CH_ADC       18
`define VIU_NUSED        19

`define VIU_RESET_WORD   32'h0000_0000

`endif

// file: bench/irq_checker_properties.sv
// checker for the vectored irq unit, sees only its top ports
// assumes the unit's single-cycle wishbone answer and its register map
`timescale 1ns/1ps
`include "vectored_irq_unit_defines.vh"
module irq_checker (
    input wire        clk_i,
    input wire        rst_i,
    input wire        cyc_i,
    input wire        stb_i,
    input wire        we_i,
    input wire [11:0] adr_i,
    input wire [31:0] dat_o,
    input wire        ack_o,
    input wire        watchdog_request_i,
    input wire        fast_request_o,
    input wire        normal_request_o,
    input wire        irq_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
wire req = cyc_i && stb_i && !ack_o;
wire rd  = req && !we_i;
wire wr  = req && we_i;
// outputs stay quiet until software has opened an enable or the mask
reg  en_seen_q;
reg  mask_seen_q;
always @(posedge clk_i)
begin
    en_seen_q   <= !rst_i && (en_seen_q || (wr && adr_i == `VIU_ENABLE));
    mask_seen_q <= !rst_i && (mask_seen_q || (wr && adr_i == `VIU_EVT_MASK));
end
property p_ack_pulse; ack_o |=> !ack_o; endproperty
a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
property p_ack_req; req |=> ack_o; endproperty
a_ack_req: assert property (p_ack_req) else $error("ack missing");
property p_no_spur; ack_o |-> $past(req); endproperty
a_no_spur: assert property (p_no_spur) else $error("stray ack");
property p_idle_zero; !ack_o |-> dat_o == 32'h0; endproperty
a_idle_zero: assert property (p_idle_zero) else $error("data idle");
property p_raw; rd && adr_i == `VIU_RAW_STATUS
    |=> dat_o[0] == $past(watchdog_request_i); endproperty
a_raw: assert property (p_raw) else $error("raw bit 0");
property p_unmap; rd && adr_i == 12'h0F0 |=> ack_o && dat_o == 32'h0;
endproperty
a_unmap: assert property (p_unmap) else $error("unmapped read");
property p_fast_gate; !en_seen_q |-> !fast_request_o; endproperty
a_fast_gate: assert property (p_fast_gate) else $error("fast gate");
property p_norm_gate; !en_seen_q |-> !normal_request_o; endproperty
a_norm_gate: assert property (p_norm_gate) else $error("normal gate");
property p_irq_gate; !mask_seen_q |-> !irq_o; endproperty
a_irq_gate: assert property (p_irq_gate) else $error("irq unmasked");
c_read: cover property (rd ##1 ack_o);
c_both: cover property (fast_request_o && normal_request_o);
c_irq: cover property (irq_o);
endmodule // irq_checker

bind vectored_irq_unit irq_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .dat_o(dat_o), .ack_o(ack_o), .watchdog_request_i(watchdog_request_i),
    .fast_request_o(fast_request_o), .normal_request_o(normal_request_o),
    .irq_o(irq_o));

// file: bench/core_model.sv
// processor core model taking the fast and normal requests
// assumes both requests are levels in the clk_i domain
`timescale 1ns/1ps
module core_model (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       fast_request_i,
    input  wire       normal_request_i,
    output reg  [1:0] taken_o
);
// fast entry is taken first; software then reads the vector word
always @(posedge clk_i)
begin
    if (rst_i)
        taken_o <= 2'h0;
    else if (fast_request_i)
        taken_o <= 2'h2;
    else if (normal_request_i)
        taken_o <= 2'h1;
    else
        taken_o <= 2'h0;
end
endmodule // core_model

// file: bench/tb.sv
// self-checking bench for the vectored irq unit with a core model
// assumes one ack per wishbone request and registered request outputs
`timescale 1ns/1ps
`include "vectored_irq_unit_defines.vh"
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
    err_count++; $display("unexpected %s exp %h seen %h", n, e, s); end end
module tb;
logic        clk_i = 0;
logic        rst_i = 1;
logic        cyc_i = 0;
logic        stb_i = 0;
logic        we_i  = 0;
logic [11:0] adr_i = 12'h000;
logic [31:0] dat_i = 32'h0;
logic [20:0] rq    = 21'h0;
logic [31:0] exp_q[$];
logic [31:0] exp_d, a0, a5, dflt, v;
wire  [31:0] dat_o;
wire         ack_o, fast_request_o, normal_request_o, irq_o;
wire  [1:0]  taken;
integer      seed = 97272, err_count = 0, num_checks = 0, cyc_n = 0;
always #25 clk_i = ~clk_i;
vectored_irq_unit uut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .watchdog_request_i(rq[0]),
    .debug_comm_receive_i(rq[2]), .debug_comm_transmit_i(rq[3]),
    .timer0_match_i(rq[4]), .timer1_match_i(rq[5]),
    .serial0_request_i(rq[6]), .serial1_request_i(rq[7]),
    .pwm_match_i(rq[8]), .two_wire_state_i(rq[9]),
    .spi0_request_i(rq[10]), .spi1_request_i(rq[11]),
    .sync_port_request_i(rq[19]), .synth_lock_flag_i(rq[12]),
    .clock_increment_flag_i(rq[13]), .clock_alarm_flag_i(rq[20]),
    .ext_request_zero_i(rq[14]), .ext_request_one_i(rq[15]),
    .ext_request_two_i(rq[16]), .ext_request_three_i(rq[17]),
    .adc_done_i(rq[18]), .fast_request_o(fast_request_o),
    .normal_request_o(normal_request_o), .irq_o(irq_o));
core_model core (.clk_i(clk_i), .rst_i(rst_i),
    .fast_request_i(fast_request_o), .normal_request_i(normal_request_o),
    .taken_o(taken));
task final_report;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
endtask
task wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
endtask
task rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
endtask
task put(input logic [20:0] r);
    @(posedge clk_i);
    rq <= r;
endtask
// five edges: two-flop sync, registered output, the core model flop, then one spare
task outs(input logic f, input logic n, input logic [1:0] t, input logic i);
    repeat (5) @(posedge clk_i);
    `CHK("fast", f, fast_request_o)
    `CHK("normal", n, normal_request_o)
    `CHK("core", t, taken)
    `CHK("irq", i, irq_o)
endtask
// ----------------------------------------------------------------
// monitor: every read answer is matched to the oldest note
// ----------------------------------------------------------------
always @(posedge clk_i)
begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000)
    begin
        err_count++;
        final_report;
    end
    if (ack_o === 1'b1 && we_i === 1'b0)
    begin
        exp_d = exp_q.pop_front();
        `CHK("read data", exp_d, dat_o)
    end
end
initial
begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`VIU_ENABLE, 32'h0);
    rd(`VIU_CLASS_SEL, 32'h0);
    rd(12'h0F0, 32'h0);
    dflt = $random(seed);
    a0 = $random(seed);
    a5 = $random(seed);
    wb(1, `VIU_DEF_ADDR, dflt);
    wb(1, `VIU_SLOT_ADDR, a0);
    wb(1, `VIU_SLOT_ADDR + 12'h014, a5);
    wb(1, `VIU_SLOT_CTRL, 32'h26);
    wb(1, `VIU_SLOT_CTRL + 12'h004, 32'h24);
    wb(1, `VIU_SLOT_CTRL + 12'h014, 32'h28);
    rd(`VIU_VECT_ADDR, dflt);
    put(21'h150);
    outs(0, 0, 0, 0);
    rd(`VIU_RAW_STATUS, 32'h150);
    wb(1, `VIU_CLASS_SEL, 32'h10);
    wb(1, `VIU_ENABLE, 32'h7FFFF);
    outs(1, 1, 2, 0);
    rd(`VIU_FAST_STATUS, 32'h10);
    rd(`VIU_IRQ_STATUS, 32'h140);
    rd(`VIU_VECT_ADDR, a0);
    wb(1, `VIU_ENABLE_CLR, 32'h40);
    rd(`VIU_VECT_ADDR, a5);
    rd(`VIU_RAW_STATUS, 32'h150);
    wb(1, `VIU_CLASS_SEL, 32'h0);
    rd(`VIU_VECT_ADDR, 32'h0);
    outs(0, 1, 1, 0);
    v = ($random(seed) & 32'h3C000) | 32'h4000;
    put(v[20:0]);
    outs(0, 1, 1, 0);
    rd(`VIU_IRQ_STATUS, v);
    rd(`VIU_VECT_ADDR, dflt);
    put(21'h18_0000);
    outs(0, 1, 1, 0);
    rd(`VIU_RAW_STATUS, 32'h2800);
    put(21'h0);
    wb(1, `VIU_SOFT_SET, 32'h1);
    rd(`VIU_RAW_STATUS, 32'h2);
    outs(0, 1, 1, 0);
    wb(1, `VIU_SOFT_CLR, 32'h1);
    outs(0, 0, 0, 0);
    wb(1, `VIU_EVT_STATUS, 32'h7);
    wb(1, `VIU_EVT_MASK, 32'h1);
    wb(1, `VIU_CLASS_SEL, 32'h10);
    put(21'h10);
    outs(1, 0, 2, 1);
    rd(`VIU_EVT_STATUS, 32'h1);
    wb(1, `VIU_EVT_MASK, 32'h0);
    outs(1, 0, 2, 0);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`VIU_ENABLE, 32'h0);
    outs(0, 0, 0, 0);
    repeat (3) @(posedge clk_i);
    final_report;
end
endmodule // tb
